// *** afesc_top.sv ***
// sampling mode, auto-cycle and clamp timing control with an AHB-Lite register slave
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps

// How it works
// - pixel colour mode samples, converts all three
// - mono samples one chosen input, own channel
// - line mode routes chosen input to red
// - line mode powers down green and blue
// - cycle pin pulses step colour and coefficients
// - register commands can set other colour sequences
// - clamp pulse timed from clock, sample pulse
// - clamp switch closed only while pulse active
// - clamp pin sampled at sample-pulse clock edge
// - sampled high arms clamp, low suppresses it
// - two-bit position places clamp and reset sample
// - auto-cycling makes internal enable decide clamping
// - reference DAC driven from four-bit code
// - range bit enlarges reference DAC range
// - external reference bit disables reference DAC
// - double sampling set references reset level
// - double sampling clear samples reference pin
// - clamping works with either referencing mode
// - each channel gets own gain and offset
// - sixteen-bit word out in bytes or nibbles
// - frame bit lets register pick line colour
module afesc_top
  import afesc_pkg::*;
(
  input wire logic clk, // master clock
  input wire logic rstn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic pixelSamplePulse, // per-pixel sample pulse pin
  input wire logic clampCyclePin, // clamp level or cycle pulse pin
  input wire logic [15:0] adcWord, // converter result
  input wire logic adcDone, // result valid pulse
  output logic internalClampPulse, // closes the clamp switch
  output logic resetSampleStrobe, // reset level sampling instant
  output logic videoSampleStrobe, // video level sampling instant
  output logic refPinSampleStrobe, // reference pin sampling instant
  output logic refFromReset, // high: reference is reset level
  output logic [2:0] sampleEnable, // channels that sample, r g b
  output logic [2:0] channelPower, // channel power, r g b
  output logic [1:0] redInputSelect, // input feeding red channel
  output logic clampRefDacEnable, // reference DAC drives the pin
  output logic [3:0] clampRefCode, // reference DAC code
  output logic clampRefRange, // reference DAC wide range
  output logic [7:0] redGain, // red channel gain
  output logic [7:0] redOffset, // red channel offset
  output logic [7:0] greenGain, // green channel gain
  output logic [7:0] greenOffset, // green channel offset
  output logic [7:0] blueGain, // blue channel gain
  output logic [7:0] blueOffset, // blue channel offset
  output logic convStart, // start one conversion
  output logic [1:0] convChannel, // channel to convert
  output logic [7:0] dataOut, // output data bus
  output logic dataOe // output bus enable
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pixMeta; // sync stage one
    logic pixSync; // sync stage two
    logic pixLast; // edge detect
    logic pinMeta; // sync stage one
    logic pinSync; // sync stage two
    logic pinLast; // edge detect
    logic [3:0] pixCnt; // cycles since pixel edge
    logic inPixel; // counter running
    logic clampArm; // clamp wanted on next reset level
    logic [1:0] colour; // auto-cycle colour
    afesc_mode_t mode; // sampling mode
    logic [1:0] monoSel; // mono input
    logic cycleFn; // pin is the cycle input
    logic frameMode; // colour from register
    logic [1:0] intColour; // register colour
    logic nibble; // nibble output format
    logic [1:0] rsPos; // reset sample position
    logic intClampEn; // clamp enable under auto-cycle
    logic [3:0] refCode; // reference DAC code
    logic refRange; // reference DAC range
    logic dacOn; // reference DAC drives pin
    logic cdsEn; // double sampling
    logic [2:0][15:0] coef; // offset and gain per colour
    logic pend; // data phase pending
    logic pendWrite; // pending is a write
    logic pendWord; // pending is a word access
    logic [7:0] pendAddr; // pending byte address
    logic hreadyout; // bus ready out
    logic [31:0] hrdata; // bus read data
    logic clampPulse; // clamp pulse
    logic resetStrobe; // reset sample
    logic videoStrobe; // video sample
    logic refStrobe; // reference pin sample
    logic refReset; // referencing select
    logic [2:0] sampleEn; // sampling channels
    logic [2:0] power; // powered channels
    logic [1:0] redSrc; // red channel input
    logic [2:0][7:0] gain; // gain outputs
    logic [2:0][7:0] offset; // offset outputs
    logic conv; // conversion start
    logic [1:0] convCh; // conversion channel
    logic pixAll; // three conversions
    logic [15:0] shiftWord; // remaining output bits
    logic [1:0] shiftLeft; // chunks still to send
    logic [7:0] dout; // data bus
    logic doe; // data enable
  } afesc_state_t;

  afesc_state_t r; // registered state
  afesc_state_t next_r; // next state
  logic rstnMeta; // reset sync stage one
  logic rstnSync; // released reset

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // red, green, blue, then red again
  function automatic logic [1:0] colourNext(input logic [1:0] c);
    colourNext = (c == AFESC_BLUE) ? AFESC_RED : c + 2'h1;
  endfunction : colourNext

  // an unused colour code falls back to red
  function automatic logic [1:0] colourLegal(input logic [1:0] c);
    colourLegal = (c > AFESC_BLUE) ? AFESC_RED : c;
  endfunction : colourLegal

  // top chunk of a word for the bus
  function automatic logic [7:0] chunk(input logic [15:0] w, input logic nib);
    chunk = nib ? {w[15:12], 4'h0} : w[15:8];
  endfunction : chunk

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // release is synchronous so all state leaves reset on one edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstnMeta <= 1'b1;
      rstnSync <= rstnMeta;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic pixEdge; // new pixel
    logic pinEdge; // cycle pulse
    logic autoOn; // pin drives auto-cycle
    logic [1:0] lineColour; // active line colour
    logic [1:0] procCh; // single processing channel
    logic [3:0] rsAt; // reset sample cycle
    logic accept; // address phase taken
    pixEdge = 1'b0;
    pinEdge = 1'b0;
    autoOn = 1'b0;
    lineColour = AFESC_RED;
    procCh = AFESC_RED;
    rsAt = 4'h0;
    accept = 1'b0;
    next_r = r;

    // pins pass two flops before use
    next_r.pixMeta = pixelSamplePulse;
    next_r.pixSync = r.pixMeta;
    next_r.pixLast = r.pixSync;
    next_r.pinMeta = clampCyclePin;
    next_r.pinSync = r.pinMeta;
    next_r.pinLast = r.pinSync;
    pixEdge = r.pixSync & ~r.pixLast;
    pinEdge = r.pinSync & ~r.pinLast;
    autoOn = r.cycleFn;

    if (autoOn && !r.frameMode && (r.mode == AFESC_LINE) && pinEdge) begin
      next_r.colour = colourNext(r.colour);
    end

    // one edge per pixel restarts timing
    if (pixEdge) begin
      next_r.pixCnt = 4'h0;
      next_r.inPixel = 1'b1;
      if (autoOn) begin
        next_r.clampArm = r.intClampEn;
      end else begin
        next_r.clampArm = r.pinSync;
      end
    end else if (r.inPixel) begin
      // stop at the end rather than wrap
      next_r.pixCnt = r.pixCnt + 4'h1;
      if (r.pixCnt == AFESC_PIX_LAST - 4'h1) begin
        next_r.inPixel = 1'b0;
      end
    end

    rsAt = AFESC_RS_BASE + {2'b00, r.rsPos};
    next_r.clampPulse = next_r.inPixel && next_r.clampArm &&
                        (next_r.pixCnt >= rsAt) &&
                        (next_r.pixCnt < rsAt + AFESC_CLAMP_LEN);
    // reset level sampled regardless of clamp
    next_r.resetStrobe = next_r.inPixel && r.cdsEn && (next_r.pixCnt == rsAt);
    next_r.videoStrobe = pixEdge;
    // reference pin with the video level
    next_r.refStrobe = pixEdge && !r.cdsEn;
    next_r.refReset = r.cdsEn;

    lineColour = r.frameMode ? colourLegal(r.intColour) : r.colour;

    // channel routing by mode
    next_r.gain[1] = r.coef[1][AFESC_GAIN_LSB +: 8];
    next_r.offset[1] = r.coef[1][AFESC_OFFSET_LSB +: 8];
    next_r.gain[2] = r.coef[2][AFESC_GAIN_LSB +: 8];
    next_r.offset[2] = r.coef[2][AFESC_OFFSET_LSB +: 8];
    next_r.gain[0] = r.coef[0][AFESC_GAIN_LSB +: 8];
    next_r.offset[0] = r.coef[0][AFESC_OFFSET_LSB +: 8];
    case (r.mode)
      AFESC_MONO: begin
        procCh = colourLegal(r.monoSel);
        next_r.sampleEn = 3'b001 << procCh;
        next_r.power = 3'b111;
        next_r.redSrc = AFESC_RED;
      end
      AFESC_LINE: begin
        procCh = AFESC_RED;
        next_r.sampleEn = 3'b001;
        next_r.redSrc = lineColour;
        next_r.power = 3'b001;
        next_r.gain[0] = r.coef[lineColour][AFESC_GAIN_LSB +: 8];
        next_r.offset[0] = r.coef[lineColour][AFESC_OFFSET_LSB +: 8];
      end
      default: begin
        procCh = AFESC_RED;
        next_r.sampleEn = 3'b111;
        next_r.power = 3'b111;
        next_r.redSrc = AFESC_RED;
      end
    endcase

    // schedule fixed at pixel start
    if (pixEdge) begin
      next_r.pixAll = (next_r.sampleEn == 3'b111);
    end

    // conversion schedule inside the pixel
    if (next_r.pixAll) begin
      next_r.conv = next_r.inPixel && (next_r.pixCnt >= AFESC_CONV_AT) &&
                    (next_r.pixCnt < AFESC_CONV_AT + 4'h3);
      next_r.convCh = 2'(next_r.pixCnt - AFESC_CONV_AT);
    end else begin
      next_r.conv = next_r.inPixel && (next_r.pixCnt == AFESC_CONV_AT);
      next_r.convCh = procCh;
    end

    // word out as two bytes or four nibbles
    if (adcDone) begin
      // a new word cuts short any old one
      next_r.dout = chunk(adcWord, r.nibble);
      next_r.shiftWord = r.nibble ? {adcWord[11:0], 4'h0} : {adcWord[7:0], 8'h00};
      next_r.shiftLeft = r.nibble ? 2'h3 : 2'h1;
      next_r.doe = 1'b1;
    end else if (r.shiftLeft != 2'h0) begin
      next_r.dout = chunk(r.shiftWord, r.nibble);
      next_r.shiftWord = r.nibble ? {r.shiftWord[11:0], 4'h0} : {r.shiftWord[7:0], 8'h00};
      next_r.shiftLeft = r.shiftLeft - 2'h1;
    end else begin
      next_r.doe = 1'b0;
      next_r.dout = 8'h00;
    end

    // bus address phase, one wait state per transfer
    accept = hsel && htrans[1] && hready;
    if (accept) begin
      next_r.pend = 1'b1;
      next_r.pendWrite = hwrite;
      next_r.pendWord = (hsize == 3'h2);
      next_r.pendAddr = haddr[7:0];
      next_r.hreadyout = 1'b0;
    end

    // data phase: hwdata stands now
    if (r.pend) begin
      next_r.pend = 1'b0;
      next_r.hreadyout = 1'b1;
      next_r.hrdata = 32'h0000_0000;
      if (r.pendWrite && r.pendWord) begin
        if (r.pendAddr == AFESC_OFF_MODE) begin
          // a code past line mode falls back to pixel mode
          if (hwdata[AFESC_MODE_LSB +: 2] > 2'h2) begin
            next_r.mode = AFESC_PIXEL;
          end else begin
            next_r.mode = afesc_mode_t'(hwdata[AFESC_MODE_LSB +: 2]);
          end
          next_r.monoSel = hwdata[AFESC_MONO_LSB +: 2];
          next_r.cycleFn = hwdata[AFESC_CYCLEFN_BIT];
          next_r.frameMode = hwdata[AFESC_FRAME_BIT];
          next_r.intColour = hwdata[AFESC_INTCOL_LSB +: 2];
          next_r.nibble = hwdata[AFESC_NIBBLE_BIT];
        end else if (r.pendAddr == AFESC_OFF_CLAMP) begin
          next_r.rsPos = hwdata[AFESC_RSPOS_LSB +: 2];
          next_r.intClampEn = hwdata[AFESC_INTCLAMP_BIT];
          next_r.refCode = hwdata[AFESC_REFCODE_LSB +: 4];
          next_r.refRange = hwdata[AFESC_RANGE_BIT];
          next_r.dacOn = ~hwdata[AFESC_EXTREF_BIT];
          next_r.cdsEn = hwdata[AFESC_CDS_BIT];
        end else if (r.pendAddr == AFESC_OFF_CMD) begin
          if (hwdata[AFESC_CMD_RED_BIT]) begin
            next_r.colour = AFESC_RED;
          end else if (hwdata[AFESC_CMD_ADV_BIT]) begin
            next_r.colour = colourNext(r.colour);
          end
        end else if (r.pendAddr == AFESC_OFF_COEF_R) begin
          next_r.coef[0] = hwdata[15:0];
        end else if (r.pendAddr == AFESC_OFF_COEF_G) begin
          next_r.coef[1] = hwdata[15:0];
        end else if (r.pendAddr == AFESC_OFF_COEF_B) begin
          next_r.coef[2] = hwdata[15:0];
        end
        // unmapped writes are dropped with an okay answer
      end else if (!r.pendWrite) begin
        if (r.pendAddr == AFESC_OFF_MODE) begin
          next_r.hrdata[AFESC_MODE_LSB +: 2] = r.mode;
          next_r.hrdata[AFESC_MONO_LSB +: 2] = r.monoSel;
          next_r.hrdata[AFESC_CYCLEFN_BIT] = r.cycleFn;
          next_r.hrdata[AFESC_FRAME_BIT] = r.frameMode;
          next_r.hrdata[AFESC_INTCOL_LSB +: 2] = r.intColour;
          next_r.hrdata[AFESC_NIBBLE_BIT] = r.nibble;
        end else if (r.pendAddr == AFESC_OFF_CLAMP) begin
          next_r.hrdata[AFESC_RSPOS_LSB +: 2] = r.rsPos;
          next_r.hrdata[AFESC_INTCLAMP_BIT] = r.intClampEn;
          next_r.hrdata[AFESC_REFCODE_LSB +: 4] = r.refCode;
          next_r.hrdata[AFESC_RANGE_BIT] = r.refRange;
          next_r.hrdata[AFESC_EXTREF_BIT] = ~r.dacOn;
          next_r.hrdata[AFESC_CDS_BIT] = r.cdsEn;
        end else if (r.pendAddr == AFESC_OFF_STATUS) begin
          // live colour, arm and clamp state
          next_r.hrdata[1:0] = lineColour;
          next_r.hrdata[2] = r.clampArm;
          next_r.hrdata[3] = r.clampPulse;
        end else if (r.pendAddr == AFESC_OFF_COEF_R) begin
          next_r.hrdata[15:0] = r.coef[0];
        end else if (r.pendAddr == AFESC_OFF_COEF_G) begin
          next_r.hrdata[15:0] = r.coef[1];
        end else if (r.pendAddr == AFESC_OFF_COEF_B) begin
          next_r.hrdata[15:0] = r.coef[2];
        end
        // command and unmapped reads give zero
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      r <= '0;
      r.mode <= AFESC_PIXEL;
      r.cdsEn <= AFESC_RST_CDS;
      r.refReset <= AFESC_RST_CDS;
      r.coef <= {3{AFESC_RST_OFFSET, AFESC_RST_GAIN}};
      r.offset <= {3{AFESC_RST_OFFSET}};
      r.gain <= {3{AFESC_RST_GAIN}};
      r.sampleEn <= 3'b111;
      r.power <= 3'b111;
      r.hreadyout <= 1'b1;
      r.dacOn <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flops, hresp tied low
  // ---------------------------------------------------------------
  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  assign hresp = 1'b0;
  assign internalClampPulse = r.clampPulse;
  assign resetSampleStrobe = r.resetStrobe;
  assign videoSampleStrobe = r.videoStrobe;
  assign refPinSampleStrobe = r.refStrobe;
  assign refFromReset = r.refReset;
  assign sampleEnable = r.sampleEn;
  assign channelPower = r.power;
  assign redInputSelect = r.redSrc;
  assign clampRefDacEnable = r.dacOn;
  assign clampRefCode = r.refCode;
  assign clampRefRange = r.refRange;
  assign redGain = r.gain[0];
  assign redOffset = r.offset[0];
  assign greenGain = r.gain[1];
  assign greenOffset = r.offset[1];
  assign blueGain = r.gain[2];
  assign blueOffset = r.offset[2];
  assign convStart = r.conv;
  assign convChannel = r.convCh;
  assign dataOut = r.dout;
  assign dataOe = r.doe;

endmodule : afesc_top

// *** afesc_pkg.sv ***
// shared constants and types for the sampling and clamp control block
package afesc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] AFESC_OFF_MODE = 8'h00;
  localparam logic [7:0] AFESC_OFF_CLAMP = 8'h04;
  localparam logic [7:0] AFESC_OFF_CMD = 8'h08;
  localparam logic [7:0] AFESC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] AFESC_OFF_COEF_R = 8'h10;
  localparam logic [7:0] AFESC_OFF_COEF_G = 8'h14;
  localparam logic [7:0] AFESC_OFF_COEF_B = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int AFESC_MODE_LSB = 0;
  localparam int AFESC_MONO_LSB = 2;
  localparam int AFESC_CYCLEFN_BIT = 4;
  localparam int AFESC_FRAME_BIT = 5;
  localparam int AFESC_INTCOL_LSB = 6;
  localparam int AFESC_NIBBLE_BIT = 8;
  localparam int AFESC_RSPOS_LSB = 0;
  localparam int AFESC_INTCLAMP_BIT = 2;
  localparam int AFESC_REFCODE_LSB = 3;
  localparam int AFESC_RANGE_BIT = 7;
  localparam int AFESC_EXTREF_BIT = 8;
  localparam int AFESC_CDS_BIT = 9;
  localparam int AFESC_CMD_ADV_BIT = 0;
  localparam int AFESC_CMD_RED_BIT = 1;
  localparam int AFESC_GAIN_LSB = 0;
  localparam int AFESC_OFFSET_LSB = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic AFESC_RST_CDS = 1'b1;
  localparam logic [7:0] AFESC_RST_GAIN = 8'h00;
  localparam logic [7:0] AFESC_RST_OFFSET = 8'h80;

  // ---------------------------------------------------------------
  // timing within a pixel, in master clock cycles after the edge
  // ---------------------------------------------------------------
  localparam logic [3:0] AFESC_RS_BASE = 4'h2;
  localparam logic [3:0] AFESC_CLAMP_LEN = 4'h2;
  localparam logic [3:0] AFESC_CONV_AT = 4'h1;
  localparam logic [3:0] AFESC_PIX_LAST = 4'hF;

  // ---------------------------------------------------------------
  // sampling modes and colours
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {AFESC_PIXEL, AFESC_MONO, AFESC_LINE} afesc_mode_t;
  localparam logic [1:0] AFESC_RED = 2'h0;
  localparam logic [1:0] AFESC_GREEN = 2'h1;
  localparam logic [1:0] AFESC_BLUE = 2'h2;

endpackage : afesc_pkg

// *** afesc_chk.sv ***
// assertion checker for the sampling and clamp control block
`timescale 1ns/1ps
module afesc_chk (
  input wire logic clk, // master clock
  input wire logic rstn, // reset, active low
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic internalClampPulse, // clamp switch
  input wire logic resetSampleStrobe, // reset sample
  input wire logic videoSampleStrobe, // video sample
  input wire logic refPinSampleStrobe, // ref pin sample
  input wire logic refFromReset, // reference choice
  input wire logic [2:0] sampleEnable, // sampling channels
  input wire logic [2:0] channelPower, // powered channels
  input wire logic convStart, // conversion request
  input wire logic [1:0] convChannel, // channel converted
  input wire logic dataOe // output enable
);
  // one clock domain, so defaults save repetition
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_bus_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus wait not one cycle");
  a_clamp_two_cycles: assert property (
    $rose(internalClampPulse) |=> internalClampPulse ##1 !internalClampPulse)
    else $error("clamp pulse not two cycles");
  a_clamp_position: assert property (
    $rose(internalClampPulse) |-> $past(videoSampleStrobe, 2) || $past(videoSampleStrobe, 3)
    || $past(videoSampleStrobe, 4) || $past(videoSampleStrobe, 5))
    else $error("clamp outside reset window");
  a_pixel_three_conv: assert property (
    videoSampleStrobe && sampleEnable == 3'h7 |=> convStart && convChannel == 2'h0
    ##1 convStart && convChannel == 2'h1 ##1 convStart && convChannel == 2'h2)
    else $error("pixel mode conversions wrong");
  a_reset_needs_cds: assert property (resetSampleStrobe |-> refFromReset)
    else $error("reset sample without double sampling");
  a_refpin_with_video: assert property (
    refPinSampleStrobe |-> videoSampleStrobe && !refFromReset)
    else $error("reference pin sample misplaced");
  a_power_pair: assert property (channelPower[1] == channelPower[2])
    else $error("green and blue power differ");
  a_out_chunks: assert property ($rose(dataOe) |=> dataOe ##[1:3] !dataOe)
    else $error("output enable length wrong");
endmodule : afesc_chk

bind afesc_top afesc_chk chk_u (.clk, .rstn, .hsel, .htrans, .hready, .hreadyout,
  .internalClampPulse, .resetSampleStrobe, .videoSampleStrobe, .refPinSampleStrobe,
  .refFromReset, .sampleEnable, .channelPower, .convStart, .convChannel, .dataOe);

// *** afesc_pix_model.sv ***
// pixel timing controller model: sample pulse and clamp or cycle pin
`timescale 1ns/1ps
module afesc_pix_model (
  input wire logic clk, // master clock
  input wire logic rstn, // reset, active low
  input wire logic run, // pulses enabled
  input wire logic clampLevel, // clamp wanted next pixel
  input wire logic cycleMode, // pin steps colours
  output logic pixelSamplePulse, // sample pulse
  output logic clampCyclePin // clamp level or step pulse
);
  logic [3:0] cnt; // pixel phase, 16 clocks a pixel
  // free running phase counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  assign pixelSamplePulse = run && cnt < 4'h2;
  // level held over pulse, inverse elsewhere so a late sample shows
  assign clampCyclePin = cycleMode ? (run && cnt[3:1] == 3'h4)
    : (cnt < 4'h2 ? clampLevel : !clampLevel);
endmodule : afesc_pix_model

// *** tb_afe_sampling_clamp_control.sv ***
// self-checking bench for the sampling and clamp control block
`timescale 1ns/1ps
module tb_afe_sampling_clamp_control;
  import afesc_pkg::*;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, hready, adcDone = 0, rdPend = 0;
  logic run = 0, clampLevel = 1, cycleMode = 0, hreadyout, hresp, dataOe, convStart;
  logic internalClampPulse, resetSampleStrobe, videoSampleStrobe, refPinSampleStrobe;
  logic refFromReset, clampRefDacEnable, clampRefRange, pixelSamplePulse, clampCyclePin;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, w;
  logic [1:0] htrans = 0, convChannel, redInputSelect;
  logic [2:0] hsize = 3'h2, sampleEnable, channelPower;
  logic [15:0] adcWord = 0;
  logic [7:0] dataOut, redGain, blueGain, greenGain, redOffset, greenOffset, blueOffset, g [3];
  logic [3:0] clampRefCode, c;
  logic [31:0] expRd [$]; // expected read data
  logic [7:0] expOut [$]; // expected output chunks
  int num_errors = 0, checks = 0, nClamp = 0, nRef = 0, nRs = 0, n;
  assign hready = hreadyout; // single slave drives the bus ready
  initial forever #25 clk = ~clk;
  afesc_top dut_u (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .pixelSamplePulse, .clampCyclePin, .adcWord, .adcDone,
    .internalClampPulse, .resetSampleStrobe, .videoSampleStrobe, .refPinSampleStrobe,
    .refFromReset, .sampleEnable, .channelPower, .redInputSelect, .clampRefDacEnable,
    .clampRefCode, .clampRefRange, .redGain, .redOffset, .greenGain, .greenOffset,
    .blueGain, .blueOffset, .convStart, .convChannel, .dataOut, .dataOe);
  afesc_pix_model ctl_u (.clk, .rstn, .run, .clampLevel, .cycleMode, .pixelSamplePulse,
    .clampCyclePin);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task hold(input int k);
    repeat (k) @(posedge clk);
  endtask : hold
  // bounded wait for hready
  task waitRdy;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("hreadyout", 1, 0);
      stop_test();
    end
  endtask : waitRdy
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    waitRdy();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    expRd.push_back(e);
    bus(0, a, 0);
  endtask : rd
  // settle, then count over four pixels
  task window;
    hold(40);
    nClamp = 0;
    nRef = 0;
    nRs = 0;
    hold(64);
  endtask : window
  // monitor: compare with oldest note
  always @(posedge clk) begin
    nClamp += internalClampPulse;
    nRef += refPinSampleStrobe;
    nRs += resetSampleStrobe;
    if (rdPend && hreadyout) begin
      rdPend <= 0;
      chk("hrdata", expRd.size() ? expRd.pop_front() : 32'hDEAD, hrdata);
      chk("hresp", 0, hresp);
    end
    if (hsel && htrans[1] && hready && !hwrite) rdPend <= 1;
    if (dataOe === 1'b1) chk("dataOut", expOut.size() ? expOut.pop_front() : 8'h5A, dataOut);
  end
  initial begin
    void'($urandom(33));
    hold(6);
    rstn <= 1;
    hold(4);
    rd(AFESC_OFF_COEF_R, 32'h8000);
    rd(AFESC_OFF_CLAMP, 32'h200);
    rd(8'h40, 32'h0);
    chk("refFromReset", 1, refFromReset);
    for (int i = 0; i < 3; i++) begin
      g[i] = 8'($urandom());
      bus(1, AFESC_OFF_COEF_R + 8'(4 * i), {16'h0, 8'h80 - g[i], g[i]});
    end
    rd(AFESC_OFF_COEF_G, {16'h0, 8'h80 - g[1], g[1]});
    chk("blueGain", g[2], blueGain);
    chk("greenGain", g[1], greenGain);
    chk("greenOffset", 8'(8'h80 - g[1]), greenOffset);
    chk("blueOffset", 8'(8'h80 - g[2]), blueOffset);
    $display("test registers done");
    bus(1, AFESC_OFF_MODE, 32'h2);
    bus(1, AFESC_OFF_CMD, 32'h1);
    hold(2);
    chk("channelPower", 3'h1, channelPower);
    chk("sampleEnable", 3'h1, sampleEnable);
    chk("redInputSelect", AFESC_GREEN, redInputSelect);
    chk("redGain", g[1], redGain);
    bus(1, AFESC_OFF_CMD, 32'h3);
    hold(2);
    chk("redInputSelect", AFESC_RED, redInputSelect);
    bus(1, AFESC_OFF_MODE, 32'hA2);
    hold(2);
    chk("redInputSelect", AFESC_BLUE, redInputSelect);
    bus(1, AFESC_OFF_MODE, 32'h12);
    bus(1, AFESC_OFF_CLAMP, 32'h204);
    run <= 1;
    cycleMode <= 1;
    clampLevel <= 0;
    for (int i = 1; i < 4; i++) begin
      n = 0;
      while (redInputSelect !== 2'(i % 3) && n < 40) begin
        @(posedge clk);
        n++;
      end
      if (n >= 40) chk("colourStep", 1, 0);
      if (n >= 40) stop_test();
      hold(2);
      chk("redInputSelect", i % 3, redInputSelect);
      chk("redGain", g[i % 3], redGain);
      chk("redOffset", 8'(8'h80 - g[i % 3]), redOffset);
    end
    window();
    chk("clampAuto", 1, nClamp > 0);
    cycleMode <= 0;
    $display("test line mode done");
    bus(1, AFESC_OFF_MODE, 32'h0);
    window();
    chk("clampLow", 0, nClamp > 0);
    chk("sampleEnable", 3'h7, sampleEnable);
    clampLevel <= 1;
    c = 4'($urandom());
    bus(1, AFESC_OFF_CLAMP, {23'h0, 2'h3, c, 3'h1});
    window();
    chk("clampHigh", 1, nClamp > 0);
    chk("refPinStrobe", 1, nRef > 0);
    chk("resetStrobe", 0, nRs > 0);
    chk("clampRefCode", c, clampRefCode);
    chk("clampRefRange", 1, clampRefRange);
    chk("clampRefDacEnable", 0, clampRefDacEnable);
    bus(1, AFESC_OFF_MODE, 32'h9);
    hold(2);
    chk("sampleEnable", 3'h4, sampleEnable);
    $display("test clamp and modes done");
    for (int m = 0; m < 2; m++) begin
      bus(1, AFESC_OFF_MODE, 32'(m) << 8);
      w = $urandom();
      for (int k = 3; k >= 0; k -= 2 - m) begin
        expOut.push_back(m ? {w[4 * k +: 4], 4'h0} : w[4 * k - 4 +: 8]);
      end
      adcWord <= w[15:0];
      adcDone <= 1;
      @(posedge clk);
      adcDone <= 0;
      hold(8);
    end
    chk("outQueue", 0, expOut.size());
    $display("test output done");
    stop_test();
  end
endmodule : tb_afe_sampling_clamp_control
